// ---- dbg_cmp_defines.svh ----
// register offsets, field positions and reset values of the comparator match block
`ifndef DBG_CMP_DEFINES_SVH
`define DBG_CMP_DEFINES_SVH
`define OFS_CTRL      12'h000
`define OFS_COMP_SEL  12'h004
`define OFS_ADDR      12'h008
`define OFS_DATA      12'h00c
`define OFS_STATUS    12'h010
`define OFS_IRQ_EN    12'h014
`define OFS_IRQ_CLR   12'h018
`define OFS_SEQ       12'h01c
`define OFS_SEQ_CFG   12'h020
`define BIT_SZE       7
`define BIT_SZ        6
`define BIT_TAG       5
`define BIT_BRK       4
`define BIT_RW        3
`define BIT_RWE       2
`define BIT_NDB       1
`define BIT_COMPARATOR_ON     0
`define CTRL_BIT_ARM  0
`define CTRL_BIT_BRKEN 1
`define CTRL_BIT_TRACE 2
`define CTRL_BIT_ENDAL 3
`define SEL_A         2'h0
`define SEL_B         2'h1
`define SEL_C         2'h2
`define SEL_NONE      2'h3
`define NUM_CMP       3
`define ST_MATCH      0
`define ST_BREAK      3
`define ST_TRIG       4
`define ST_DONE       5
`define STAT_W        6
`define CTL_RST       8'h00
`define SEQ_FINAL     4'h8
`endif

// ---- dbg_cmp_pkg.sv ----
// types shared by the comparator match block
package dbg_cmp_pkg;
  typedef enum logic [3:0] {
    SEQ_ST1   = 4'h1,
    SEQ_ST2   = 4'h2,
    SEQ_ST3   = 4'h4,
    SEQ_FINAL = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        valid;
    logic        read;
    logic        byte_acc;
    logic        bdm_acc;
  } cpu_bus_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] cmp;
  } exec_t;

  typedef struct packed {
    logic [2:0][7:0]  ctl;
    logic [2:0][15:0] addr;
    logic [7:0]  data;
    logic [1:0]  sel;
    logic        armed;
    logic        brk_en;
    logic        trace_en;
    logic        end_align;
    seq_state_t  seq;
    logic [2:0]  tag_pend;
    logic [5:0]  status;
    logic [5:0]  irq_en;
    logic        irq;
    logic        immediate_session_stop;
    logic        trace;
    logic        trig;
    logic [2:0]  match;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [1:0]  bdm_sync;
    logic [1:0]  sec_sync;
  } dbg_state_t;
endpackage

// ---- dbg_cmp_match.sv ----
// comparator qualification, sequencer and apb registers of the debug unit
// Functional notes
// R1: size compare enable bit makes access width part of match, not under tag
// R2: size value bit: 0 word, 1 byte; ignored if size off or tagging
// R3: tag clear acts at once; tag set acts when tagged opcode executes
// R4: break bit ends session at match: break, stop trace, disarm
// R5: immediate breakpoint only when global breakpoint enable is set
// R6: direction value bit: 0 write, 1 read; ignored if compare off or tag
// R7: direction compare enable adds direction to match; ignored under tag
// R8: comparator a only: data mismatch select matches difference, ignored under tag
// R9: comparator matches only while its enable bit is set
// R10: bank select 00, 01, 10 picks comparator a, b, c for reads and writes
// R11: control writes take effect only while the unit is disarmed
// R12: no monitoring during background accesses or while background unit is active
// R13: entering active background while armed keeps the unit armed
// R14: secured chip disables tracing; matches, tags and breaks still work
// R15: works in every operating mode, limited only by background and security
// R16: four-stage sequencer; trace trigger tied to final state
// R17: trace supports begin and end alignment to the trigger
// R18: match needs address hit and every enabled qualifier in one cycle
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "dbg_cmp_defines.svh"

module dbg_cmp_match
  import dbg_cmp_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // processor side, same clock
  input  wire cpu_bus_t    cpu_bus,
  input  wire exec_t       exec,
  // background debug and security pins
  input  wire logic        bdm_active_pin,
  input  wire logic        secure_pin,
  // results
  output logic             breakpoint,
  output logic             trace_run,
  output logic             trace_trigger,
  output logic             end_align,
  output logic [2:0]       cmp_match,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  dbg_state_t st_ff;
  dbg_state_t nxt_st;

  // register map, one 32-bit word each, fields in the low bits:
  //   0x00 control: end alignment b3, trace enable b2, global breakpoint enable b1, arm b0
  //   0x04 comparator_control of the comparator picked by the bank select
  //   0x08 comparator_bank_select b1:0 (11 names no comparator and is dropped)
  //   0x0c comparator a data b7:0
  //   0x10 status, read only: done b5, trigger b4, break b3, match c..a b2:0
  //   0x14 interrupt enable, same layout as status
  //   0x18 status clear, write 1 to clear, reads 0
  //   0x1c sequencer stage, one-hot 1, 2, 4, 8
  //   0x20 address of the comparator picked by the bank select
  // any other offset answers with pslverr; a write there is dropped, a read gives 0

  // background and security levels pass two flops held in st_ff before use;
  // the two-cycle lag means a match can still fire just after the pin rises
  wire logic bdm_active = st_ff.bdm_sync[1];
  wire logic secured    = st_ff.sec_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // per comparator qualification
  logic [2:0] hit;
  logic [2:0] imm_hit;
  logic [2:0] tag_hit;

  // R12 monitoring gate
  wire logic monitor = cpu_bus.valid && !cpu_bus.bdm_acc && !bdm_active;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CMP; gi++) begin : g_cmp
      logic [7:0] c;
      logic       size_compare_enable;
      logic       size_value_select;
      logic       tag_select;
      logic       direction_value;
      logic       direction_compare_enable;
      logic       data_mismatch_select;
      logic       comparator_on;
      logic       addr_hit;
      logic       size_ok;
      logic       dir_ok;
      logic       data_ok;
      assign c = st_ff.ctl[gi];
      assign size_compare_enable      = c[`BIT_SZE];
      assign size_value_select        = c[`BIT_SZ];
      assign tag_select               = c[`BIT_TAG];
      assign direction_value          = c[`BIT_RW];
      assign direction_compare_enable = c[`BIT_RWE];
      assign data_mismatch_select     = c[`BIT_NDB];
      assign comparator_on            = c[`BIT_COMPARATOR_ON];
      assign addr_hit                 = (cpu_bus.addr == st_ff.addr[gi]);
      // R1 size compare on a and b
      // R2 word or byte select
      if (gi < 2) begin : g_size
        assign size_ok = tag_select || !size_compare_enable ||
                         (size_value_select == cpu_bus.byte_acc);
      end else begin : g_nosize
        // comparator c has no size bits; whatever is stored there is ignored
        assign size_ok = 1'b1;
      end
      // R7 direction compare enable
      // R6 read or write value
      assign dir_ok = tag_select || !direction_compare_enable ||
                      (direction_value == cpu_bus.read);
      // R8 data equal or differ on a
      if (gi == 0) begin : g_data
        assign data_ok = tag_select ||
                         ((cpu_bus.data != st_ff.data) == data_mismatch_select);
      end else begin : g_nodata
        assign data_ok = 1'b1;
      end
      // R9 comparator enable
      // R18 all qualifiers in one cycle
      assign hit[gi] = monitor && comparator_on && addr_hit && size_ok && dir_ok && data_ok;
      // R3 immediate or tagged
      assign imm_hit[gi] = hit[gi] && !tag_select;
      assign tag_hit[gi] = hit[gi] && tag_select;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  sel_ctl;
  logic [15:0] sel_addr;
  logic [31:0] rd;
  logic        ok;
  logic [2:0]  fire;
  logic        adv;
  logic        brk_fire;
  logic        wr;
  logic        rdacc;
  logic [5:0]  evt;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  logic setup_ph;
  logic setup_rd;
  logic hit_ctrl;
  logic hit_cmp_ctl;
  logic hit_bank;
  logic hit_cmp_data;
  logic hit_status;
  logic hit_irq_en;
  logic hit_irq_clr;
  logic hit_seq;
  logic hit_cmp_addr;
  logic addr_ok;
  logic access_wr;
  logic cfg_open;
  logic bank_ok;

  // the answer is fixed at one access cycle, so the setup phase alone raises pready;
  // a master that stretches the access phase sees pready for its first cycle only
  assign setup_ph     = psel && !penable;
  assign setup_rd     = setup_ph && !pwrite;
  assign access_wr    = psel && penable && pwrite;
  assign hit_ctrl     = (paddr == `OFS_CTRL);
  assign hit_cmp_ctl  = (paddr == `OFS_COMP_SEL);
  assign hit_bank     = (paddr == `OFS_ADDR);
  assign hit_cmp_data = (paddr == `OFS_DATA);
  assign hit_status   = (paddr == `OFS_STATUS);
  assign hit_irq_en   = (paddr == `OFS_IRQ_EN);
  assign hit_irq_clr  = (paddr == `OFS_IRQ_CLR);
  assign hit_seq      = (paddr == `OFS_SEQ);
  assign hit_cmp_addr = (paddr == `OFS_SEQ_CFG);
  assign addr_ok      = hit_ctrl || hit_cmp_ctl || hit_bank || hit_cmp_data || hit_status ||
                        hit_irq_en || hit_irq_clr || hit_seq || hit_cmp_addr;
  // R11 comparator set-up is frozen while armed; the write is dropped without an error
  assign cfg_open     = !st_ff.armed && (st_ff.sel != `SEL_NONE);
  // R10 bank select 11 names no comparator, so a write of it is dropped
  assign bank_ok      = (pwdata[1:0] != `SEL_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // next state, in this order:
  //   comparator fire and tag bookkeeping, from the registered set-up
  //   sequencer stage and trigger, then the trace window from the new stage
  //   break handling, which overrides trace and arming
  //   register writes, so software can re-arm in the same cycle as a break
  //   status events last, so an event wins over a clear in the same cycle
  // a write to the control word in the same cycle as a break re-arms the unit;
  // software is expected to disarm before it reprograms anything
  always_comb begin
    nxt_st = st_ff;
    rd = 32'h0000_0000;
    ok = addr_ok;
    fire = 3'h0;
    adv = 1'b0;
    brk_fire = 1'b0;
    evt = 6'h00;
    wr = access_wr;
    // two-flop synchronisers; only the second stage is read by any logic
    nxt_st.bdm_sync = {st_ff.bdm_sync[0], bdm_active_pin};
    nxt_st.sec_sync = {st_ff.sec_sync[0], secure_pin};
    rdacc = psel && penable && !pwrite;
    // R10 bank select picks the comparator
    unique case (st_ff.sel)
      `SEL_A: begin
        sel_ctl  = st_ff.ctl[0];
        sel_addr = st_ff.addr[0];
      end
      `SEL_B: begin
        sel_ctl  = st_ff.ctl[1];
        sel_addr = st_ff.addr[1];
      end
      `SEL_C: begin
        sel_ctl  = st_ff.ctl[2];
        sel_addr = st_ff.addr[2];
      end
      default: begin
        sel_ctl  = 8'h00;
        sel_addr = 16'h0000;
      end
    endcase
    // R3 tagged opcode fires at execution
    // a tag stays pending until that comparator's opcode executes or a break
    // clears it; an opcode flushed from the queue leaves a stale tag behind
    for (int i = 0; i < `NUM_CMP; i++) begin
      if (tag_hit[i] && st_ff.armed)
        nxt_st.tag_pend[i] = 1'b1;
      fire[i] = st_ff.armed && (imm_hit[i] ||
                (st_ff.tag_pend[i] && exec.valid && exec.cmp == i[1:0]));
      if (exec.valid && exec.cmp == i[1:0])
        nxt_st.tag_pend[i] = 1'b0;
      // R4 break bit ends session
      if (fire[i] && st_ff.ctl[i][`BIT_BRK])
        brk_fire = 1'b1;
    end
    adv = |fire;
    nxt_st.match = fire;
    nxt_st.immediate_session_stop = 1'b0;
    nxt_st.trig = 1'b0;
    // R16 four stage sequencer
    if (adv && st_ff.armed) begin
      unique case (st_ff.seq)
        SEQ_ST1: nxt_st.seq = SEQ_ST2;
        SEQ_ST2: nxt_st.seq = SEQ_ST3;
        SEQ_ST3: nxt_st.seq = SEQ_FINAL;
        SEQ_FINAL: nxt_st.seq = SEQ_FINAL;
      endcase
    end
    // R16 trigger at final state
    if (adv && st_ff.armed && st_ff.seq == SEQ_ST3)
      nxt_st.trig = 1'b1;
    // R14 secure blocks trace only
    // R17 begin align runs from trigger, end align runs until trigger
    nxt_st.trace = st_ff.armed && st_ff.trace_en && !secured &&
                   (st_ff.end_align ? (nxt_st.seq != SEQ_FINAL)
                                    : (nxt_st.seq == SEQ_FINAL));
    if (brk_fire) begin
      // R5 break needs global enable
      nxt_st.immediate_session_stop = st_ff.brk_en;
      nxt_st.armed = 1'b0;
      nxt_st.trace = 1'b0;
      nxt_st.tag_pend = 3'h0;
    end
    // R13 bdm entry does not touch the armed bit
    // R15 no mode gating beyond bdm and security
    if (st_ff.armed && nxt_st.seq == SEQ_FINAL && !st_ff.end_align && st_ff.seq != SEQ_FINAL)
      nxt_st.status[`ST_TRIG] = 1'b1;
    // register access, single cycle answer
    unique case (paddr)
      `OFS_CTRL:     rd = {28'h0, st_ff.end_align, st_ff.trace_en, st_ff.brk_en, st_ff.armed};
      `OFS_COMP_SEL: rd = {24'h0, sel_ctl};
      `OFS_ADDR:     rd = {30'h0, st_ff.sel};
      `OFS_DATA:     rd = {24'h0, st_ff.data};
      `OFS_STATUS:   rd = {26'h0, st_ff.status};
      `OFS_IRQ_EN:   rd = {26'h0, st_ff.irq_en};
      `OFS_IRQ_CLR:  rd = 32'h0000_0000;
      `OFS_SEQ:      rd = {28'h0, st_ff.seq};
      `OFS_SEQ_CFG:  rd = {16'h0, sel_addr};
      default:       rd = 32'h0000_0000;
    endcase
    if (wr && hit_ctrl) begin
      nxt_st.armed = pwdata[`CTRL_BIT_ARM];
      nxt_st.brk_en = pwdata[`CTRL_BIT_BRKEN];
      nxt_st.trace_en = pwdata[`CTRL_BIT_TRACE];
      nxt_st.end_align = pwdata[`CTRL_BIT_ENDAL];
      if (pwdata[`CTRL_BIT_ARM] && !st_ff.armed)
        nxt_st.seq = SEQ_ST1;
    end
    // R11 writes only while disarmed
    if (wr && hit_cmp_ctl && cfg_open)
      nxt_st.ctl[st_ff.sel] = pwdata[7:0];
    if (wr && hit_bank && bank_ok)
      nxt_st.sel = pwdata[1:0];
    if (wr && hit_cmp_data && !st_ff.armed)
      nxt_st.data = pwdata[7:0];
    if (wr && hit_irq_en)
      nxt_st.irq_en = pwdata[5:0];
    if (wr && hit_irq_clr)
      nxt_st.status = st_ff.status & ~pwdata[5:0];
    if (wr && hit_cmp_addr && cfg_open)
      nxt_st.addr[st_ff.sel] = pwdata[15:0];
    // events set status; set wins over clear
    evt[`NUM_CMP-1:`ST_MATCH] = fire;
    evt[`ST_BREAK] = brk_fire;
    evt[`ST_TRIG]  = nxt_st.trig;
    evt[`ST_DONE]  = brk_fire || (st_ff.armed && !nxt_st.armed);
    nxt_st.status = nxt_st.status | evt;
    nxt_st.irq = |(nxt_st.status & nxt_st.irq_en);
    // answer registered from the setup phase: pready and error stand for exactly
    // the first access cycle; read data then holds until the next read setup phase
    nxt_st.pready = setup_ph;
    nxt_st.pslverr = setup_ph && !ok;
    nxt_st.prdata = setup_rd ? rd : st_ff.prdata;
    if (rdacc) nxt_st.prdata = st_ff.prdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.ctl       <= {`NUM_CMP{`CTL_RST}};
      st_ff.addr      <= '0;
      st_ff.data      <= 8'h00;
      st_ff.sel       <= `SEL_A;
      st_ff.armed     <= 1'b0;
      st_ff.brk_en    <= 1'b0;
      st_ff.trace_en  <= 1'b0;
      st_ff.end_align <= 1'b0;
      st_ff.seq       <= SEQ_ST1;
      st_ff.tag_pend  <= 3'h0;
      st_ff.status    <= 6'h00;
      st_ff.irq_en    <= 6'h00;
      st_ff.irq       <= 1'b0;
      st_ff.immediate_session_stop       <= 1'b0;
      st_ff.trace     <= 1'b0;
      st_ff.trig      <= 1'b0;
      st_ff.match     <= 3'h0;
      st_ff.pready    <= 1'b0;
      st_ff.pslverr   <= 1'b0;
      st_ff.prdata    <= 32'h0000_0000;
      st_ff.bdm_sync  <= 2'h0;
      st_ff.sec_sync  <= 2'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // every output is a field of st_ff:
  //   breakpoint, trace_trigger and cmp_match are one-cycle pulses, one cycle
  //   after the bus cycle that caused them; breakpoint only with global enable
  //   trace_run and end_align are levels; trace_run drops three cycles after secure_pin rises
  //   irq follows status and enable, changing at the same edge as either of them
  assign prdata        = st_ff.prdata;
  assign pready        = st_ff.pready;
  assign pslverr       = st_ff.pslverr;
  assign breakpoint    = st_ff.immediate_session_stop;
  assign trace_run     = st_ff.trace;
  assign trace_trigger = st_ff.trig;
  assign end_align     = st_ff.end_align;
  assign cmp_match     = st_ff.match;
  assign irq           = st_ff.irq;

endmodule

// ---- dbg_cmp_match_assertions.sv ----
// port-level checks for the comparator match block
`timescale 1ns/1ps
module dbg_cmp_match_assertions
  import dbg_cmp_pkg::*;
(
  // apb
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // processor and pins
  input wire cpu_bus_t   cpu_bus,
  input wire exec_t      exec,
  input wire logic       bdm_active_pin,
  input wire logic       secure_pin,
  // results
  input wire logic       trace_run,
  input wire logic       trace_trigger,
  input wire logic [2:0] cmp_match
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////
  a_apb_answer:
    assert property (psel && !penable |=> pready ##1 !pready) else $error("late pready");
  a_ready_access:
    assert property (pready |-> psel && penable) else $error("stray pready");
  a_err_ready:
    assert property (pslverr |-> pready) else $error("stray pslverr");
  a_bdm_access_quiet:
    assert property (cpu_bus.valid && cpu_bus.bdm_acc && !exec.valid |=> cmp_match == 3'h0)
    else $error("match on background access");
  a_bdm_active_quiet:
    assert property ($past(bdm_active_pin, 2) && $past(bdm_active_pin, 3)
      && $past(bdm_active_pin, 4) |-> cmp_match == 3'h0) else $error("match in background");
  a_secure_no_trace:
    assert property ($past(secure_pin, 2) && $past(secure_pin, 3) && $past(secure_pin, 4)
      |-> !trace_run) else $error("trace while secured");
  a_match_has_cause:
    assert property (cmp_match != 3'h0 |-> $past(cpu_bus.valid) || $past(exec.valid))
    else $error("match without access");
  a_trigger_pulse:
    assert property (trace_trigger |=> !trace_trigger) else $error("trigger too long");
endmodule
bind dbg_cmp_match dbg_cmp_match_assertions chk_i (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .cpu_bus, .exec, .bdm_active_pin, .secure_pin, .trace_run,
  .trace_trigger, .cmp_match);

// ---- cpu_side_model.sv ----
// processor bus and background pin model facing the comparator block
`timescale 1ns/1ps
module cpu_side_model
  import dbg_cmp_pkg::*;
(
  // clock
  input wire logic pclk,
  // toward the debug unit
  output cpu_bus_t cpu_bus,
  output exec_t    exec,
  output logic     bdm_active_pin,
  output logic     secure_pin
);
  initial {cpu_bus, exec, bdm_active_pin, secure_pin} = '0;
  ////////////////////////////////
  // lines flip after the cycle so stale values never look like a hit
  task access(input logic [15:0] a, input logic [7:0] d, input logic rd, by, bd);
    @(posedge pclk);
    cpu_bus <= '{a, d, 1'b1, rd, by, bd};
    @(posedge pclk);
    cpu_bus <= '{~a, ~d, 1'b0, ~rd, ~by, 1'b0};
  endtask
  task fire(input logic [1:0] c);
    @(posedge pclk);
    exec <= '{1'b1, c};
    @(posedge pclk);
    exec <= '0;
  endtask
  task pins(input logic b, s);
    @(posedge pclk);
    bdm_active_pin <= b;
    secure_pin <= s;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// ---- tb_debug_comparator_match_control.sv ----
// self-checking bench for the comparator match block
`timescale 1ns/1ps
module tb_debug_comparator_match_control import dbg_cmp_pkg::*;;
  localparam logic [11:0] CTRL = 12'h000, CCTL = 12'h004, BANK = 12'h008, DATA = 12'h00c;
  localparam logic [11:0] STAT = 12'h010, IEN = 12'h014, ICLR = 12'h018, SEQR = 12'h01c;
  localparam logic [11:0] CADR = 12'h020, HOLE = 12'h0fc;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic breakpoint, trace_run, trace_trigger, end_align, bdm_active_pin, secure_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [31:0] seed = 32'ha190;
  logic [15:0] ad;
  logic [7:0] ctl, dat, dd;
  logic [2:0] cmp_match;
  cpu_bus_t cpu_bus;
  exec_t exec;
  int err_count, compares;
  int trig_n = 0;
  dbg_cmp_match dbg_cmp_match_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .cpu_bus, .exec, .bdm_active_pin, .secure_pin, .breakpoint,
    .trace_run, .trace_trigger, .end_align, .cmp_match, .irq);
  cpu_side_model cpu_side_model_i (.pclk, .cpu_bus, .exec, .bdm_active_pin, .secure_pin);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (trace_trigger === 1'b1) trig_n <= trig_n + 1;
  ////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic hit_a(logic [7:0] c, cd, logic [15:0] a, logic [7:0] d, logic r, b);
    return c[0] && a == 16'h1234 && (!c[7] || c[6] == b) && (!c[2] || c[3] == r)
      && (c[1] ? d != cd : d == cd);
  endfunction
  task chk(input string s, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input string s, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(s, e, rd);
  endtask
  task hit(input logic [7:0] d);
    cpu_side_model_i.access(16'h1234, d, 1'b1, 1'b0, 1'b0);
    @(negedge pclk);
  endtask
  task wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    wrap_up();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc("status", STAT, '0);
    rdc("seq", SEQR, 32'h1);
    bus(1'b0, HOLE, '0);
    chk("slverr", 32'h1, 32'(err));
    wr(BANK, 32'h3);
    rdc("bank", BANK, '0);
    for (int i = 0; i < 3; i++) begin
      wr(BANK, i);
      wr(CCTL, 8'h04 + 8 * i);
    end
    for (int i = 0; i < 3; i++) begin
      wr(BANK, i);
      rdc("bank ctl", CCTL, 8'h04 + 8 * i);
    end
    wr(BANK, '0);
    wr(CADR, 32'h1234);
    for (int k = 0; k < 40; k++) begin
      v = xs();
      ctl = v[7:0] & 8'hcf;
      dat = v[15:8];
      v = xs();
      ad = {15'h091a, v[0]};
      dd = v[1] ? dat : v[15:8];
      wr(CTRL, '0);
      wr(CCTL, 32'(ctl));
      wr(DATA, 32'(dat));
      wr(CTRL, 32'h1);
      cpu_side_model_i.access(ad, dd, v[2], v[3], 1'b0);
      @(negedge pclk);
      chk("match", {31'h0, hit_a(ctl, dat, ad, dd, v[2], v[3])}, 32'(cmp_match));
    end
    wr(CCTL, 32'h1);
    wr(CTRL, '0);
    rdc("locked ctl", CCTL, 32'(ctl));
    $display("test qualifiers done");
    wr(CCTL, 32'h1);
    wr(CTRL, 32'h1);
    cpu_side_model_i.access(16'h1234, dat, 1'b1, 1'b0, 1'b1);
    @(negedge pclk);
    chk("bdm access", '0, 32'(cmp_match));
    cpu_side_model_i.pins(1'b1, 1'b0);
    hit(dat);
    chk("bdm active", '0, 32'(cmp_match));
    rdc("armed", CTRL, 32'h1);
    cpu_side_model_i.pins(1'b0, 1'b0);
    hit(dat);
    chk("match", 32'h1, 32'(cmp_match));
    for (int g = 0; g < 2; g++) begin
      wr(CTRL, '0);
      wr(CCTL, 32'h11);
      wr(CTRL, 32'(1 + 2 * g));
      hit(dat);
      chk("breakpoint", 32'(g), 32'(breakpoint));
      rdc("disarm", CTRL, 32'(2 * g));
    end
    wr(IEN, 32'h1);
    repeat (2) @(negedge pclk);
    chk("irq", 32'h1, 32'(irq));
    wr(IEN, '0);
    repeat (2) @(negedge pclk);
    chk("irq masked", '0, 32'(irq));
    wr(IEN, 32'h1);
    wr(ICLR, 32'h3f);
    rdc("cleared", STAT, '0);
    chk("irq cleared", '0, 32'(irq));
    $display("test background and break done");
    for (int a = 1; a >= 0; a--) begin
      wr(CTRL, '0);
      wr(CCTL, 32'h1);
      wr(CTRL, 32'(5 + 8 * a));
      repeat (2) @(negedge pclk);
      chk("trace before", 32'(a), 32'(trace_run));
      chk("end align", 32'(a), 32'(end_align));
      repeat (3) hit(dat);
      rdc("final", SEQR, 32'h8);
      chk("trace after", 32'(1 - a), 32'(trace_run));
    end
    chk("triggers", 32'h2, 32'(trig_n));
    cpu_side_model_i.pins(1'b0, 1'b1);
    @(negedge pclk);
    chk("secure trace", '0, 32'(trace_run));
    wr(CTRL, '0);
    wr(CCTL, 32'h21);
    wr(CTRL, 32'h1);
    hit(~dat);
    rdc("tag wait", SEQR, 32'h1);
    cpu_side_model_i.fire(2'h0);
    rdc("tag fired", SEQR, 32'h2);
    $display("test trace and tag done");
    wrap_up();
  end
endmodule
